/* lvdspc_link.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lvdspc_regs.svh"
module lvdspc_link (
  input wire logic link_clk,
  input wire logic nrst,
  input wire logic port_en,
  input wire logic req_tog,
  input wire lvdspc_pkg::lvdspc_xfer_t hold,
  output logic ack_tog,
  output logic [27:0] lane_a,
  output logic [27:0] lane_b,
  output logic lane_pwr_a,
  output logic lane_pwr_b
);

  typedef struct packed {
    logic en_s1;
    logic en_s2;
    logic req_s1;
    logic req_s2;
    logic req_prev;
    logic ack;
    logic [27:0] la;
    logic [27:0] lb;
    logic pwr_a;
    logic pwr_b;
  } lvdspc_link_st_t;

  lvdspc_link_st_t st;
  lvdspc_link_st_t next_st;

  //----------------------------------------
  // Pixel packing onto four lanes of seven
  //----------------------------------------
  function automatic logic [27:0] lvdspc_pack(input logic [23:0] rgb, input logic de,
      input logic hs, input logic vs, input logic depth24, input logic fmt24_1);
    logic [17:0] hi6;
    logic [6:0] l3;
    hi6 = {rgb[23:18], rgb[15:10], rgb[7:2]};
    l3 = 7'h00;
    if (depth24 && fmt24_1) begin
      l3 = {1'b0, rgb[1:0], rgb[9:8], rgb[17:16]};
    end else if (depth24) begin
      hi6 = {rgb[21:16], rgb[13:8], rgb[5:0]};
      l3 = {1'b0, rgb[7:6], rgb[15:14], rgb[23:22]};
    end
    return {l3, de, vs, hs, hi6};
  endfunction

  //----------------------------------------
  // Next state
  //----------------------------------------
  always_comb begin
    logic fresh;
    logic hs_b;
    logic vs_b;
    logic de_b;
    next_st = st;
    fresh = 1'b0;
    hs_b = 1'b0;
    vs_b = 1'b0;
    de_b = 1'b0;
    // Synchronisers for enable and request toggle
    next_st.en_s1 = port_en;
    next_st.en_s2 = st.en_s1;
    next_st.req_s1 = req_tog;
    next_st.req_s2 = st.req_s1;
    next_st.req_prev = st.req_s2;
    fresh = st.req_s2 ^ st.req_prev;
    // Second channel control slots
    case (hold.ch2_ctl)
      `LVDSPC_CH2_NORMAL: begin
        de_b = hold.pix_b.de;
        hs_b = hold.pix_b.hs ^ hold.hs_inv;
        vs_b = hold.pix_b.vs ^ hold.vs_inv;
      end
      `LVDSPC_CH2_AUX: begin
        hs_b = hold.aux_a;
        vs_b = hold.aux_b;
      end
      default: begin
        de_b = 1'b0;
      end
    endcase
    // Word arrives: pack it and acknowledge
    if (fresh) begin
      next_st.ack = ~st.ack;
      next_st.la = lvdspc_pack(hold.pix_a.rgb, hold.pix_a.de,
          hold.pix_a.hs ^ hold.hs_inv, hold.pix_a.vs ^ hold.vs_inv,
          hold.depth24, hold.fmt24_1);
      next_st.lb = hold.two_ch ? lvdspc_pack(hold.pix_b.rgb, de_b, hs_b, vs_b,
          hold.depth24, hold.fmt24_1) : 28'h000_0000;
      next_st.pwr_b = st.en_s2 & hold.two_ch;
    end
    next_st.pwr_a = st.en_s2;
    // Disabled port: pairs powered down and quiet
    if (!st.en_s2) begin
      next_st.la = 28'h000_0000;
      next_st.lb = 28'h000_0000;
      next_st.pwr_b = 1'b0;
    end
  end

  // State register on the link clock
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ack_tog = st.ack;
  assign lane_a = st.la;
  assign lane_b = st.lb;
  assign lane_pwr_a = st.pwr_a;
  assign lane_pwr_b = st.pwr_b;

endmodule // lvdspc_link
`default_nettype wire

/* lvdspc_panel.sv */
`timescale 1ns/1ps
`default_nettype none
module lvdspc_panel (
  input wire logic link_clk,
  input wire logic [27:0] lane_a,
  input wire logic [27:0] lane_b,
  input wire logic lane_pwr_a
);
  logic [27:0] got_a[$];
  logic [27:0] got_b[$];
  logic [55:0] last_ab = 56'h0;
  //----------------------------------------
  // Take each new word while powered
  //----------------------------------------
  always @(posedge link_clk) begin
    if (lane_pwr_a && {lane_a, lane_b} !== last_ab) begin
      got_a.push_back(lane_a);
      got_b.push_back(lane_b);
    end
    last_ab <= {lane_a, lane_b};
  end
endmodule // lvdspc_panel
`default_nettype wire

/* lvdspc_pkg.sv */
`default_nettype none
package lvdspc_pkg;

  // One pixel with its timing flags
  typedef struct packed {
    logic de;
    logic hs;
    logic vs;
    logic [23:0] rgb;
  } lvdspc_pix_t;

  // Word pair plus configuration snapshot sent to the link side
  typedef struct packed {
    lvdspc_pix_t pix_a;
    lvdspc_pix_t pix_b;
    logic two_ch;
    logic depth24;
    logic fmt24_1;
    logic [1:0] ch2_ctl;
    logic aux_a;
    logic aux_b;
    logic vs_inv;
    logic hs_inv;
  } lvdspc_xfer_t;

  // Sender handshake states
  typedef enum logic [1:0] {
    LVDSPC_IDLE = 2'b01,
    LVDSPC_BUSY = 2'b10
  } lvdspc_state_t;

endpackage
`default_nettype wire

/* lvdspc_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lvdspc_regs.svh"
module lvdspc_port (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic reg_wr_en,
  input wire logic [31:0] reg_wr_data,
  input wire logic pps_write_protect,
  output logic [31:0] reg_rd_data,
  output logic pll_lvds_mode,
  input wire logic src_a_valid,
  input wire logic [23:0] src_a_rgb,
  input wire logic src_a_de,
  input wire logic src_a_hs,
  input wire logic src_a_vs,
  output logic src_a_ready,
  input wire logic src_b_valid,
  input wire logic [23:0] src_b_rgb,
  input wire logic src_b_de,
  input wire logic src_b_hs,
  input wire logic src_b_vs,
  output logic src_b_ready,
  output logic [27:0] lane_a,
  output logic [27:0] lane_b,
  output logic lane_pwr_a,
  output logic lane_pwr_b
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic pll_mode;
    lvdspc_pkg::lvdspc_pix_t buf0;
    lvdspc_pkg::lvdspc_pix_t buf1;
    logic [1:0] cnt;
    logic rdy_a;
    logic rdy_b;
    logic half;
    lvdspc_pkg::lvdspc_state_t state;
    logic req_tog;
    logic ack_s1;
    logic ack_s2;
    logic ack_prev;
    lvdspc_pkg::lvdspc_xfer_t hold;
  } lvdspc_port_st_t;

  lvdspc_port_st_t st;
  lvdspc_port_st_t next_st;
  logic ack_tog;

  //----------------------------------------
  // Control, two-entry buffer, pairing, crossing
  //----------------------------------------
  always_comb begin
    logic push_a;
    logic push_b;
    logic pop;
    logic ack_seen;
    logic [1:0] cnt_v;
    lvdspc_pkg::lvdspc_pix_t in_pix;
    logic [1:0] sel;
    next_st = st;
    push_a = src_a_valid & st.rdy_a;
    push_b = src_b_valid & st.rdy_b;
    pop = 1'b0;
    ack_seen = st.ack_s2 ^ st.ack_prev;
    cnt_v = st.cnt;
    in_pix = push_a ? {src_a_de, src_a_hs, src_a_vs, src_a_rgb}
                    : {src_b_de, src_b_hs, src_b_vs, src_b_rgb};
    sel = 2'h0;
    // Register write, refused while the sequencer locks it
    if (reg_wr_en && !pps_write_protect) begin
      next_st.ctrl = reg_wr_data & `LVDSPC_CTRL_WMASK;
    end
    next_st.pll_mode = st.ctrl[`LVDSPC_PORT_EN];
    // Acknowledge toggle synchroniser
    next_st.ack_s1 = ack_tog;
    next_st.ack_s2 = st.ack_s1;
    next_st.ack_prev = st.ack_s2;
    case (st.state)
      lvdspc_pkg::LVDSPC_IDLE: begin
        pop = (st.cnt != 2'h0);
      end
      lvdspc_pkg::LVDSPC_BUSY: begin
        if (ack_seen) begin
          next_st.state = lvdspc_pkg::LVDSPC_IDLE;
        end
      end
      default: begin
        next_st.state = lvdspc_pkg::LVDSPC_IDLE;
      end
    endcase
    // Buffer head leaves toward the pairing stage
    if (pop) begin
      next_st.buf0 = st.buf1;
      cnt_v = cnt_v - 2'h1;
      if (!st.half) begin
        next_st.hold.pix_a = st.buf0;
        next_st.hold.pix_b = '0;
        next_st.hold.two_ch = st.ctrl[`LVDSPC_TWO_CH];
        next_st.hold.depth24 = st.ctrl[`LVDSPC_DEPTH24];
        next_st.hold.fmt24_1 = st.ctrl[`LVDSPC_FMT_24_1];
        next_st.hold.ch2_ctl = st.ctrl[`LVDSPC_CH2_HI:`LVDSPC_CH2_LO];
        next_st.hold.aux_a = st.ctrl[`LVDSPC_AUX_A_LVL];
        next_st.hold.aux_b = st.ctrl[`LVDSPC_AUX_B_LVL];
        next_st.hold.vs_inv = st.ctrl[`LVDSPC_VS_INV];
        next_st.hold.hs_inv = st.ctrl[`LVDSPC_HS_INV];
      end else begin
        next_st.hold.pix_b = st.buf0;
      end
      if (st.ctrl[`LVDSPC_TWO_CH] && !st.half) begin
        next_st.half = 1'b1;
      end else begin
        next_st.half = 1'b0;
        next_st.state = lvdspc_pkg::LVDSPC_BUSY;
        next_st.req_tog = ~st.req_tog;
      end
    end
    // Word from the selected transcoder enters the buffer
    if (push_a || push_b) begin
      if (cnt_v == 2'h0) begin
        next_st.buf0 = in_pix;
      end else begin
        next_st.buf1 = in_pix;
      end
      cnt_v = cnt_v + 2'h1;
    end
    next_st.cnt = cnt_v;
    // Ready only with room, port enabled, source selected
    sel = next_st.ctrl[`LVDSPC_XC_SEL_HI:`LVDSPC_XC_SEL_LO];
    next_st.rdy_a = (cnt_v != `LVDSPC_BUF_DEPTH) && next_st.ctrl[`LVDSPC_PORT_EN]
        && (sel == `LVDSPC_XC_A);
    next_st.rdy_b = (cnt_v != `LVDSPC_BUF_DEPTH) && next_st.ctrl[`LVDSPC_PORT_EN]
        && (sel == `LVDSPC_XC_B);
  end

  // State register on the display clock
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '{ctrl: `LVDSPC_CTRL_RESET, state: lvdspc_pkg::LVDSPC_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // Link side on its own clock
  lvdspc_link u_link (
    .link_clk(link_clk),
    .nrst(nrst),
    .port_en(st.ctrl[`LVDSPC_PORT_EN]),
    .req_tog(st.req_tog),
    .hold(st.hold),
    .ack_tog(ack_tog),
    .lane_a(lane_a),
    .lane_b(lane_b),
    .lane_pwr_a(lane_pwr_a),
    .lane_pwr_b(lane_pwr_b)
  );

  assign reg_rd_data = st.ctrl;
  assign pll_lvds_mode = st.pll_mode;
  assign src_a_ready = st.rdy_a;
  assign src_b_ready = st.rdy_b;

endmodule // lvdspc_port
`default_nettype wire

/* lvdspc_port_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lvdspc_regs.svh"
module lvdspc_port_asserts (
  input wire logic ref_clk,
  input wire logic link_clk,
  input wire logic nrst,
  input wire logic reg_wr_en,
  input wire logic [31:0] reg_wr_data,
  input wire logic pps_write_protect,
  input wire logic [31:0] reg_rd_data,
  input wire logic pll_lvds_mode,
  input wire logic src_a_ready,
  input wire logic src_b_ready,
  input wire logic [27:0] lane_a,
  input wire logic [27:0] lane_b,
  input wire logic lane_pwr_a,
  input wire logic lane_pwr_b
);
  //----------------------------------------
  // Register and lane checks
  //----------------------------------------
  AST_WR: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_wr_en && !pps_write_protect |=>
    reg_rd_data == ($past(reg_wr_data) & `LVDSPC_CTRL_WMASK)) else $error("write lost");
  AST_WP: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_wr_en && pps_write_protect |=> $stable(reg_rd_data)) else $error("locked write taken");
  AST_PLL: assert property (@(posedge ref_clk) disable iff (!nrst)
    pll_lvds_mode == $past(reg_rd_data[31])) else $error("pll mode wrong");
  AST_RDA: assert property (@(posedge ref_clk) disable iff (!nrst)
    src_a_ready |-> reg_rd_data[31:29] == 3'h4) else $error("source a ready");
  AST_RDB: assert property (@(posedge ref_clk) disable iff (!nrst)
    src_b_ready |-> reg_rd_data[31:29] == 3'h5) else $error("source b ready");
  AST_DIS: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(reg_rd_data[31]) |-> ##[1:12] !lane_pwr_a) else $error("port stays up");
  AST_MSK: assert property (@(posedge ref_clk) disable iff (!nrst)
    (reg_rd_data & ~`LVDSPC_CTRL_WMASK) == 32'h0) else $error("unmapped bit set");
  AST_OFF: assert property (@(posedge link_clk) disable iff (!nrst)
    !lane_pwr_a [*2] |-> lane_a == 28'h0 && lane_b == 28'h0) else $error("lanes live");
  AST_PWB: assert property (@(posedge link_clk) disable iff (!nrst)
    lane_pwr_b |-> lane_pwr_a) else $error("second channel alone");
endmodule // lvdspc_port_asserts
bind lvdspc_port lvdspc_port_asserts chk (.ref_clk, .link_clk, .nrst, .reg_wr_en,
  .reg_wr_data, .pps_write_protect, .reg_rd_data, .pll_lvds_mode, .src_a_ready,
  .src_b_ready, .lane_a, .lane_b, .lane_pwr_a, .lane_pwr_b);
`default_nettype wire

/* lvdspc_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin errors++; $display("unexpected %0t %s", $time, m); end end
module lvdspc_port_tb;
  logic ref_clk = 1'b0, link_clk = 1'b0, nrst = 1'b0, reg_wr_en = 1'b0;
  logic pps_write_protect = 1'b0, src_a_valid = 1'b0, src_b_valid = 1'b0;
  logic [31:0] reg_wr_data = 32'h0, seed = 32'h6F07B7F8, reg_rd_data;
  logic [26:0] pa = 27'h0, pb = 27'h0;
  logic pll_lvds_mode, src_a_ready, src_b_ready, lane_pwr_a, lane_pwr_b;
  logic [27:0] lane_a, lane_b;
  int errors = 0, checks = 0;
  lvdspc_port dut (.ref_clk, .nrst, .link_clk, .reg_wr_en, .reg_wr_data, .pps_write_protect,
    .reg_rd_data, .pll_lvds_mode, .src_a_valid, .src_a_rgb(pa[23:0]), .src_a_de(pa[26]),
    .src_a_hs(pa[25]), .src_a_vs(pa[24]), .src_a_ready, .src_b_valid, .src_b_rgb(pb[23:0]),
    .src_b_de(pb[26]), .src_b_hs(pb[25]), .src_b_vs(pb[24]), .src_b_ready, .lane_a, .lane_b,
    .lane_pwr_a, .lane_pwr_b);
  lvdspc_panel pnl (.link_clk, .lane_a, .lane_b, .lane_pwr_a);
  //----------------------------------------
  // Clocks, helpers and model
  //----------------------------------------
  initial forever #50 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #15 link_clk = ~link_clk; // Never gated
  end
  initial begin
    #2000000;
    errors++;
    conclude;
  end
  task automatic conclude;
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected lane word for one pixel
  function automatic logic [27:0] pack(input logic [26:0] p, input logic [31:0] c, input logic chb);
    logic [5:0] r, g, b;
    logic [6:0] l3;
    logic de, hs, vs;
    de = p[26];
    hs = p[25] ^ c[20];
    vs = p[24] ^ c[21];
    {r, g, b, l3} = {p[23:18], p[15:10], p[7:2], 7'h0};
    if (c[4] && !c[24]) {r, g, b, l3} = {p[21:16], p[13:8], p[5:0], 1'b0, p[7:6], p[15:14], p[23:22]};
    else if (c[4]) l3 = {1'b0, p[1:0], p[9:8], p[17:16]};
    if (chb && c[18:17] == 2'h3) {de, hs, vs} = {1'b0, c[23], c[22]};
    else if (chb && c[18:17] != 2'h0) {de, hs, vs} = 3'h0;
    return {l3, de, vs, hs, r, g, b};
  endfunction
  task automatic wr(input logic [31:0] d, input logic lock);
    @(negedge ref_clk);
    {reg_wr_en, reg_wr_data, pps_write_protect} = {1'b1, d, lock};
    @(negedge ref_clk);
    {reg_wr_en, pps_write_protect} = 2'h0;
    repeat (2) @(negedge ref_clk);
  endtask
  // Offer a pixel on the chosen source and junk on the other
  task automatic send(input logic [26:0] p, input logic sb);
    int n;
    n = 0;
    {src_a_valid, src_b_valid, pa, pb} = {2'h3, sb ? ~p : p, sb ? p : ~p};
    while (!(sb ? src_b_ready : src_a_ready) && n < 200) begin
      `CHK(sb ? src_a_ready : src_b_ready, 1'b0, "unselected source ready")
      @(negedge ref_clk);
      n++;
    end
    `CHK(n < 200, 1'b1, "source stalled")
    @(negedge ref_clk);
  endtask
  //----------------------------------------
  // Main sequence
  //----------------------------------------
  initial begin
    logic [31:0] c;
    logic [27:0] ea[$], eb[$];
    logic [26:0] p;
    int n;
    repeat (8) @(negedge ref_clk);
    nrst = 1'b1;
    `CHK({reg_rd_data, src_a_ready, src_b_ready, pll_lvds_mode}, 35'h0, "reset state")
    wr(32'hFFFFFFFF, 1'b1);
    `CHK(reg_rd_data, 32'h0, "locked write")
    wr(32'hFFFFFFFF, 1'b0);
    `CHK(reg_rd_data, 32'hE1F60030, "write mask")
    `CHK(pll_lvds_mode, 1'b1, "pll mode")
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      c = seed & 32'hA1F60030 | 32'h80000000;
      c[18:17] = i[1:0];
      wr(c, 1'b0);
      for (int k = 0; k < 4; k++) begin
        seed = lfsr(seed);
        p = seed[26:0];
        send(p, c[29]);
        if (!c[5]) begin
          ea.push_back(pack(p, c, 1'b0));
          eb.push_back(28'h0);
        end else if (k[0]) eb.push_back(pack(p, c, 1'b1));
        else ea.push_back(pack(p, c, 1'b0));
      end
      {src_a_valid, src_b_valid} = 2'h0;
      for (n = 0; n < 400 && pnl.got_a.size() < ea.size(); n++) @(negedge ref_clk);
      `CHK(pnl.got_a.size(), ea.size(), "word count")
      `CHK({lane_pwr_a, lane_pwr_b}, {1'b1, c[5]}, "lane power")
      while (ea.size() && pnl.got_a.size()) begin
        `CHK(pnl.got_a.pop_front(), ea.pop_front(), "lane a word")
        `CHK(pnl.got_b.pop_front(), eb.pop_front(), "lane b word")
      end
      ea.delete();
      eb.delete();
    end
    wr(32'h0, 1'b0);
    for (n = 0; n < 50 && lane_pwr_a; n++) @(negedge ref_clk);
    `CHK({pll_lvds_mode, lane_pwr_a, lane_pwr_b, lane_a, lane_b}, 59'h0, "port off")
    conclude;
  end
endmodule // lvdspc_port_tb
`default_nettype wire

/* lvdspc_regs.svh */
// Function
// - Port disabled: all pairs powered down
// - Port enable changes transcoder PLL programming
// - Bits 30:29 pick transcoder A or B
// - Bit 24 selects 18/24.0 or 24.1 packing
// - Bit 23 sets second channel HS level
// - Bit 22 sets second channel VS level
// - Bit 21 inverts VSYNC sent to panel
// - Power sequencer can write-protect control register
// - Bits 18:17 choose second channel control signals
// - Bit 20 inverts HSYNC sent to panel
`ifndef LVDSPC_REGS_SVH
`define LVDSPC_REGS_SVH

//----------------------------------------
// Control register layout
//----------------------------------------
`define LVDSPC_CTRL_RESET 32'h0000_0000
`define LVDSPC_CTRL_WMASK 32'hE1F6_0030
`define LVDSPC_PORT_EN 31
`define LVDSPC_XC_SEL_HI 30
`define LVDSPC_XC_SEL_LO 29
`define LVDSPC_FMT_24_1 24
`define LVDSPC_AUX_A_LVL 23
`define LVDSPC_AUX_B_LVL 22
`define LVDSPC_VS_INV 21
`define LVDSPC_HS_INV 20
`define LVDSPC_CH2_HI 18
`define LVDSPC_CH2_LO 17
`define LVDSPC_TWO_CH 5
`define LVDSPC_DEPTH24 4

//----------------------------------------
// Field codes
//----------------------------------------
`define LVDSPC_XC_A 2'h0
`define LVDSPC_XC_B 2'h1
`define LVDSPC_CH2_NORMAL 2'h0
`define LVDSPC_CH2_ZERO 2'h2
`define LVDSPC_CH2_AUX 2'h3
`define LVDSPC_BUF_DEPTH 2'h2

`endif
